// File: core/aspc_core.sv
/*
  Asynchronous serial port core: mode control, baud divider, transmit
  shifter, receive shifter with holding register and error status.
  Assumes a single-cycle register port master on clk_in, which also
  serves as the base clock of the unit.
*/
`timescale 1ns/10ps
`default_nettype none
`include "aspc_map.svh"

module aspc_core
  import aspc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // Register port
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wr_data_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output var  logic [7:0]  rd_data_out,
  // Serial pins
  input  wire logic        serial_in_pin_in,
  output var  logic        serial_out_pin_out,
  // Events
  output var  logic        transmit_done_interrupt_out,
  output var  logic        receive_done_out,
  output var  logic        receive_error_out
);

  aspc_mode_s  serial_mode_control;
  logic [4:0]  baud_generator_control;
  logic [7:0]  receive_holding;
  logic [7:0]  transmit_shifter;
  aspc_err_s   receive_error_status;
  logic        unit_rst_b;

  // Power off asynchronously resets the unit except the mode, baud and output registers
  assign unit_rst_b = rst_b_in & serial_mode_control.power;

  logic sel_mode;
  logic sel_baud;
  logic sel_data;
  logic sel_status;

  always_comb begin
    sel_mode   = 1'b0;
    sel_baud   = 1'b0;
    sel_data   = 1'b0;
    sel_status = 1'b0;
    if (addr_in == `ASPC_ADDR_MODE) begin
      sel_mode = 1'b1;
    end else if (addr_in == `ASPC_ADDR_BAUD) begin
      sel_baud = 1'b1;
    end else if (addr_in == `ASPC_ADDR_DATA) begin
      sel_data = 1'b1;
    end else if (addr_in == `ASPC_ADDR_STATUS) begin
      sel_status = 1'b1;
    end
  end

  // Bit writes arrive as byte writes of the whole value
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      serial_mode_control <= `ASPC_MODE_RESET;
    end else if (wr_in && sel_mode) begin
      serial_mode_control <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      baud_generator_control <= `ASPC_BAUD_RESET;
    end else if (wr_in && sel_baud) begin
      baud_generator_control <= wr_data_in[4:0];
    end
  end

  // Enables pass two stages on the base clock
  logic txe_s1;
  logic txe_on;
  logic rxe_s1;
  logic rxe_on;

  always_ff @(posedge clk_in or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      txe_s1 <= 1'b0;
      txe_on <= 1'b0;
      rxe_s1 <= 1'b0;
      rxe_on <= 1'b0;
    end else begin
      txe_s1 <= serial_mode_control.tx_en;
      txe_on <= txe_s1;
      rxe_s1 <= serial_mode_control.rx_en;
      rxe_on <= rxe_s1;
    end
  end

  // Receive pin synchroniser; reset value keeps the line high
  logic rx_s1;
  logic rx_s2;
  logic rx_line;

  always_ff @(posedge clk_in or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end else begin
      rx_s1 <= serial_in_pin_in;
      rx_s2 <= rx_s1;
    end
  end

  assign rx_line = serial_mode_control.power ? rx_s2 : 1'b1;

  // One bit lasts two divider periods
  logic [5:0] bit_last;
  logic [5:0] half_last;
  logic [2:0] data_last;

  assign bit_last  = {baud_generator_control, 1'b0} - 6'h01;
  assign half_last = {1'b0, baud_generator_control} - 6'h01;
  assign data_last = serial_mode_control.char8 ? `ASPC_BITS_8 : `ASPC_BITS_7;

  aspc_tx_e   tx_state;
  logic [5:0] tx_cnt;
  logic [2:0] tx_idx;
  logic       tx_par;
  logic       tx_bit_end;
  logic       tx_start;

  assign tx_bit_end = (tx_cnt == bit_last);
  // A write while busy is dropped; software waits for the done event
  assign tx_start = wr_in && sel_data && txe_on && (tx_state == ASPC_TX_IDLE);

  always_ff @(posedge clk_in or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      tx_cnt <= 6'h00;
    end else if (!txe_on || tx_state == ASPC_TX_IDLE || tx_bit_end) begin
      tx_cnt <= 6'h00;
    end else begin
      tx_cnt <= tx_cnt + 6'h01;
    end
  end

  always_ff @(posedge clk_in or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      tx_state <= ASPC_TX_IDLE;
      tx_idx   <= 3'h0;
    end else if (!txe_on) begin
      tx_state <= ASPC_TX_IDLE;
      tx_idx   <= 3'h0;
    end else begin
      case (tx_state)
        ASPC_TX_IDLE: begin
          if (tx_start) begin
            tx_state <= ASPC_TX_START;
          end
        end
        ASPC_TX_START: begin
          if (tx_bit_end) begin
            tx_state <= ASPC_TX_DATA;
            tx_idx   <= 3'h0;
          end
        end
        ASPC_TX_DATA: begin
          if (tx_bit_end) begin
            tx_idx <= tx_idx + 3'h1;
            if (tx_idx == data_last) begin
              if (serial_mode_control.parity == `ASPC_PAR_NONE) begin
                tx_state <= ASPC_TX_STOP1;
              end else begin
                tx_state <= ASPC_TX_PAR;
              end
            end
          end
        end
        ASPC_TX_PAR: begin
          if (tx_bit_end) begin
            tx_state <= ASPC_TX_STOP1;
          end
        end
        ASPC_TX_STOP1: begin
          if (tx_bit_end) begin
            if (serial_mode_control.stop2) begin
              tx_state <= ASPC_TX_STOP2;
            end else begin
              tx_state <= ASPC_TX_IDLE;
            end
          end
        end
        ASPC_TX_STOP2: begin
          if (tx_bit_end) begin
            tx_state <= ASPC_TX_IDLE;
          end
        end
        default: begin
          tx_state <= ASPC_TX_IDLE;
        end
      endcase
    end
  end

  // Shifter empties to the right, refilling with ones
  always_ff @(posedge clk_in or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      transmit_shifter <= `ASPC_DATA_RESET;
    end else if (!txe_on) begin
      transmit_shifter <= `ASPC_DATA_RESET;
    end else if (tx_start) begin
      transmit_shifter <= wr_data_in;
    end else if (tx_state == ASPC_TX_DATA && tx_bit_end) begin
      transmit_shifter <= {1'b1, transmit_shifter[7:1]};
    end
  end

  always_ff @(posedge clk_in or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      tx_par <= 1'b0;
    end else if (tx_start) begin
      tx_par <= 1'b0;
    end else if (tx_state == ASPC_TX_DATA && tx_bit_end) begin
      tx_par <= tx_par ^ transmit_shifter[0];
    end
  end

  logic next_serial_out;

  always_comb begin
    next_serial_out = 1'b1;
    case (tx_state)
      ASPC_TX_START: begin
        next_serial_out = 1'b0;
      end
      ASPC_TX_DATA: begin
        next_serial_out = transmit_shifter[0];
      end
      ASPC_TX_PAR: begin
        if (serial_mode_control.parity == `ASPC_PAR_ODD) begin
          next_serial_out = ~tx_par;
        end else if (serial_mode_control.parity == `ASPC_PAR_EVEN) begin
          next_serial_out = tx_par;
        end else begin
          next_serial_out = 1'b0;
        end
      end
      default: begin
        next_serial_out = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      serial_out_pin_out          <= 1'b1;
      transmit_done_interrupt_out <= 1'b0;
    end else begin
      serial_out_pin_out          <= next_serial_out;
      transmit_done_interrupt_out <= txe_on && tx_bit_end &&
        ((tx_state == ASPC_TX_STOP2) ||
         (tx_state == ASPC_TX_STOP1 && !serial_mode_control.stop2));
    end
  end

  aspc_rx_e   rx_state;
  logic [5:0] rx_cnt;
  logic [2:0] rx_idx;
  logic [7:0] receive_shifter;
  logic       rx_par;
  logic       rx_full;
  logic       rx_sample;
  logic       rx_finish;
  logic       rx_pe;
  logic       rx_rd_data;
  logic       rx_rd_status;

  assign rx_sample    = (rx_state == ASPC_RX_START) ? (rx_cnt == half_last) : (rx_cnt == bit_last);
  assign rx_finish    = rxe_on && rx_state == ASPC_RX_STOP && rx_sample;
  assign rx_rd_data   = rd_in && sel_data;
  assign rx_rd_status = rd_in && sel_status;

  // Odd or even mode only; zero parity is never judged
  always_comb begin
    rx_pe = 1'b0;
    if (serial_mode_control.parity == `ASPC_PAR_ODD) begin
      rx_pe = ~rx_par;
    end else if (serial_mode_control.parity == `ASPC_PAR_EVEN) begin
      rx_pe = rx_par;
    end
  end

  always_ff @(posedge clk_in or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      rx_cnt <= 6'h00;
    end else if (!rxe_on || rx_state == ASPC_RX_IDLE || rx_sample) begin
      rx_cnt <= 6'h00;
    end else begin
      rx_cnt <= rx_cnt + 6'h01;
    end
  end

  always_ff @(posedge clk_in or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      rx_state <= ASPC_RX_IDLE;
      rx_idx   <= 3'h0;
    end else if (!rxe_on) begin
      rx_state <= ASPC_RX_IDLE;
      rx_idx   <= 3'h0;
    end else begin
      case (rx_state)
        ASPC_RX_IDLE: begin
          // A low line right after enable starts a frame at once
          if (!rx_line) begin
            rx_state <= ASPC_RX_START;
          end
        end
        ASPC_RX_START: begin
          if (rx_sample) begin
            rx_idx <= 3'h0;
            if (rx_line) begin
              rx_state <= ASPC_RX_IDLE;
            end else begin
              rx_state <= ASPC_RX_DATA;
            end
          end
        end
        ASPC_RX_DATA: begin
          if (rx_sample) begin
            rx_idx <= rx_idx + 3'h1;
            if (rx_idx == data_last) begin
              if (serial_mode_control.parity == `ASPC_PAR_NONE) begin
                rx_state <= ASPC_RX_STOP;
              end else begin
                rx_state <= ASPC_RX_PAR;
              end
            end
          end
        end
        ASPC_RX_PAR: begin
          if (rx_sample) begin
            rx_state <= ASPC_RX_STOP;
          end
        end
        ASPC_RX_STOP: begin
          if (rx_sample) begin
            rx_state <= ASPC_RX_IDLE;
          end
        end
        default: begin
          rx_state <= ASPC_RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      receive_shifter <= 8'h00;
      rx_par          <= 1'b0;
    end else if (!rxe_on || rx_state == ASPC_RX_IDLE) begin
      receive_shifter <= 8'h00;
      rx_par          <= 1'b0;
    end else if (rx_state == ASPC_RX_DATA && rx_sample) begin
      receive_shifter <= {rx_line, receive_shifter[7:1]};
      rx_par          <= rx_par ^ rx_line;
    end else if (rx_state == ASPC_RX_PAR && rx_sample) begin
      rx_par <= rx_par ^ rx_line;
    end
  end

  // Holding register survives a receive disable, only reset or power off clears it
  always_ff @(posedge clk_in or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      receive_holding <= `ASPC_DATA_RESET;
    end else if (rx_finish && !rx_full) begin
      if (serial_mode_control.char8) begin
        receive_holding <= receive_shifter;
      end else begin
        receive_holding <= {1'b0, receive_shifter[7:1]};
      end
    end
  end

  // New data wins over a read in the same cycle
  always_ff @(posedge clk_in or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      rx_full <= 1'b0;
    end else if (!rxe_on) begin
      rx_full <= 1'b0;
    end else if (rx_finish && !rx_full) begin
      rx_full <= 1'b1;
    end else if (rx_rd_data) begin
      rx_full <= 1'b0;
    end
  end

  // Sticky errors: a new event beats the clear on read
  always_ff @(posedge clk_in or negedge unit_rst_b) begin
    if (!unit_rst_b) begin
      receive_error_status <= `ASPC_STATUS_RESET;
    end else if (!rxe_on) begin
      receive_error_status <= `ASPC_STATUS_RESET;
    end else begin
      if (rx_finish && rx_pe) begin
        receive_error_status.parity_err <= 1'b1;
      end else if (rx_rd_status) begin
        receive_error_status.parity_err <= 1'b0;
      end
      if (rx_finish && !rx_line) begin
        receive_error_status.frame_err <= 1'b1;
      end else if (rx_rd_status) begin
        receive_error_status.frame_err <= 1'b0;
      end
      if (rx_finish && rx_full) begin
        receive_error_status.overrun <= 1'b1;
      end else if (rx_rd_status) begin
        receive_error_status.overrun <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      receive_done_out  <= 1'b0;
      receive_error_out <= 1'b0;
    end else begin
      receive_done_out  <= rx_finish && !rx_full;
      receive_error_out <= rx_finish && (rx_pe || !rx_line || rx_full);
    end
  end

  // Data address reads the receive holding; unmapped addresses read zero
  logic [7:0] next_rd_data;

  always_comb begin
    next_rd_data = 8'h00;
    if (sel_mode) begin
      next_rd_data = serial_mode_control;
    end else if (sel_baud) begin
      next_rd_data = {3'h0, baud_generator_control};
    end else if (sel_data) begin
      next_rd_data = receive_holding;
    end else if (sel_status) begin
      next_rd_data = {5'h00, receive_error_status};
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_data_out <= 8'h00;
    end else if (rd_in) begin
      rd_data_out <= next_rd_data;
    end else begin
      rd_data_out <= 8'h00;
    end
  end

endmodule // aspc_core

`default_nettype wire

// File: core/aspc_map.svh
/*
  Register offsets, field positions, reset values and timing constants
  of the asynchronous serial port core.
  Assumes a 16-bit byte address on the register port.
*/
// Overview of operation
// - Each complete received character is copied into the 8-bit receive holding register unless it is still full.
// - In 7-bit mode received data fills bits 0 to 6, bit 7 reads zero.
// - On overrun the new character is dropped and the holding register kept.
// - Receive holding is read only, all ones after reset or power off.
// - Writing the transmit shifter starts a frame on the serial output pin.
// - Transmit shifter is write only, all ones on reset, power off, transmit disable.
// - Mode control is one byte, byte or bit writable, resets to 0x01.
// - Power bit low holds the unit in asynchronous reset, status and data included.
// - Power bit low makes the receiver see a constant high line.
// - Transmit enable low disables and synchronously resets the transmitter.
// - Receive enable low disables and synchronously resets the receiver.
// - Parity field: none, zero bit, odd, even, for both directions.
// - Zero parity mode never checks parity and never flags a parity error.
// - Character length bit selects 7 data bits at zero, 8 at one.
// - Stop select gives one or two transmit stop bits; receiver always expects one.
// - Enabling reception while the line is low starts a reception at once.
// - Enables pass a two-stage sync; re-enable no sooner than two base clocks.
// - Characters travel least significant bit first.
// - Bit rate is the divider output clock halved.
`ifndef ASPC_MAP_SVH
`define ASPC_MAP_SVH

`define ASPC_ADDR_MODE      16'hff70
`define ASPC_ADDR_BAUD      16'hff71
`define ASPC_ADDR_DATA      16'hff72
`define ASPC_ADDR_STATUS    16'hff73

`define ASPC_MODE_RESET     8'h01
`define ASPC_BAUD_RESET     5'h1f
`define ASPC_DATA_RESET     8'hff
`define ASPC_STATUS_RESET   3'h0

`define ASPC_BIT_POWER      7
`define ASPC_BIT_TXE        6
`define ASPC_BIT_RXE        5
`define ASPC_BIT_PE         2
`define ASPC_BIT_FE         1
`define ASPC_BIT_OVE        0

`define ASPC_PAR_NONE       2'h0
`define ASPC_PAR_ZERO       2'h1
`define ASPC_PAR_ODD        2'h2
`define ASPC_PAR_EVEN       2'h3

`define ASPC_BITS_7         3'h6
`define ASPC_BITS_8         3'h7

`endif

// File: core/aspc_pkg.sv
/*
  Types of the asynchronous serial port core.
  Assumes aspc_map.svh for the numeric constants.
*/
package aspc_pkg;

  typedef struct packed {
    logic       power;
    logic       tx_en;
    logic       rx_en;
    logic [1:0] parity;
    logic       char8;
    logic       stop2;
    logic       fixed_one;
  } aspc_mode_s;

  typedef struct packed {
    logic parity_err;
    logic frame_err;
    logic overrun;
  } aspc_err_s;

  typedef enum logic [2:0] {
    ASPC_TX_IDLE,
    ASPC_TX_START,
    ASPC_TX_DATA,
    ASPC_TX_PAR,
    ASPC_TX_STOP1,
    ASPC_TX_STOP2
  } aspc_tx_e;

  typedef enum logic [2:0] {
    ASPC_RX_IDLE,
    ASPC_RX_START,
    ASPC_RX_DATA,
    ASPC_RX_PAR,
    ASPC_RX_STOP
  } aspc_rx_e;

endpackage

// File: testbench/aspc_core_properties.sv
/* Port checker of the serial core, bound to aspc_core.
   Assumes one clock and single-cycle register strobes. */
`timescale 1ns/10ps
`default_nettype none
`include "aspc_map.svh"
module aspc_core_properties (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  // Register port
  input wire logic [15:0] addr_in,
  input wire logic [7:0]  wr_data_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [7:0]  rd_data_out,
  // Serial pins and events
  input wire logic        serial_in_pin_in,
  input wire logic        serial_out_pin_out,
  input wire logic        transmit_done_interrupt_out,
  input wire logic        receive_done_out,
  input wire logic        receive_error_out
);
  logic [7:0] mode;
  logic [3:0] tx_off;
  logic [3:0] rx_off;

  // Shadow of the mode register as software wrote it
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode <= `ASPC_MODE_RESET;
    end else if (wr_in && addr_in == `ASPC_ADDR_MODE) begin
      mode <= wr_data_in;
    end
  end

  // Cycles since a direction went off; slack covers the enable sync
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_off <= 4'hf;
      rx_off <= 4'hf;
    end else begin
      tx_off <= (mode[7] && mode[6]) ? 4'h0 : (tx_off == 4'hf) ? tx_off : tx_off + 4'h1;
      rx_off <= (mode[7] && mode[5]) ? 4'h0 : (rx_off == 4'hf) ? rx_off : rx_off + 4'h1;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  property p_rd_quiet;
    !$past(rd_in) |-> rd_data_out == 8'h00;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("read data not zero outside a read");
  property p_mode_read;
    rd_in && addr_in == `ASPC_ADDR_MODE |=> rd_data_out == $past(mode);
  endproperty
  a_mode_read: assert property (p_mode_read)
    else $error("mode read differs from written value");
  property p_holding_off;
    rd_in && addr_in == `ASPC_ADDR_DATA && !mode[7] |=> rd_data_out == 8'hff;
  endproperty
  a_holding_off: assert property (p_holding_off)
    else $error("holding not all ones while unpowered");
  property p_status_off;
    rd_in && addr_in == `ASPC_ADDR_STATUS && !mode[7] |=> rd_data_out == 8'h00;
  endproperty
  a_status_off: assert property (p_status_off)
    else $error("error status set while unpowered");
  property p_tx_off_idle;
    tx_off >= 4'h4 |-> serial_out_pin_out && !transmit_done_interrupt_out;
  endproperty
  a_tx_off_idle: assert property (p_tx_off_idle)
    else $error("transmitter active while disabled");
  property p_rx_off_quiet;
    rx_off >= 4'h4 |-> !receive_done_out && !receive_error_out;
  endproperty
  a_rx_off_quiet: assert property (p_rx_off_quiet)
    else $error("receiver active while disabled");
  property p_done_pulse;
    transmit_done_interrupt_out |=> !transmit_done_interrupt_out;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("transmit done longer than one cycle");
  property p_done_after_stop;
    transmit_done_interrupt_out |-> $past(serial_out_pin_out) && $past(serial_out_pin_out, 8);
  endproperty
  a_done_after_stop: assert property (p_done_after_stop)
    else $error("transmit done without a high stop bit");
  property p_low_bit_len;
    $fell(serial_out_pin_out) |-> !serial_out_pin_out [*8];
  endproperty
  a_low_bit_len: assert property (p_low_bit_len)
    else $error("low bit shorter than eight cycles");
endmodule // aspc_core_properties

bind aspc_core aspc_core_properties u_props (
  .clk_in                      (clk_in),
  .rst_b_in                    (rst_b_in),
  .addr_in                     (addr_in),
  .wr_data_in                  (wr_data_in),
  .wr_in                       (wr_in),
  .rd_in                       (rd_in),
  .rd_data_out                 (rd_data_out),
  .serial_in_pin_in            (serial_in_pin_in),
  .serial_out_pin_out          (serial_out_pin_out),
  .transmit_done_interrupt_out (transmit_done_interrupt_out),
  .receive_done_out            (receive_done_out),
  .receive_error_out           (receive_error_out)
);
`default_nettype wire

// File: testbench/aspc_core_test.sv
/* Self-checking bench of the serial core against a remote device.
   Assumes aspc_map.svh on the include path. */
`timescale 1ns/10ps
`default_nettype none
`include "aspc_map.svh"
module aspc_core_test;
  localparam int BAUD_K = 8;
  logic        clk_in;
  logic        rst_b_in;
  logic [15:0] addr_in;
  logic [7:0]  wr_data_in;
  logic        wr_in;
  logic        rd_in;
  logic [7:0]  rd_data_out;
  logic        rx_line;
  logic        tx_line;
  logic        tx_done;
  logic        rx_done;
  logic        rx_err;
  logic [15:0] rx_ev = 16'h0000;
  int          mismatches;
  int          tests_run;

  aspc_core DUT (
    .clk_in                      (clk_in),
    .rst_b_in                    (rst_b_in),
    .addr_in                     (addr_in),
    .wr_data_in                  (wr_data_in),
    .wr_in                       (wr_in),
    .rd_in                       (rd_in),
    .rd_data_out                 (rd_data_out),
    .serial_in_pin_in            (rx_line),
    .serial_out_pin_out          (tx_line),
    .transmit_done_interrupt_out (tx_done),
    .receive_done_out            (rx_done),
    .receive_error_out           (rx_err)
  );
  aspc_remote #(.K(BAUD_K)) remote (.clk_in(clk_in), .tx_line_in(tx_line), .rx_line_out(rx_line));

  // Receive pulses counted: done in the low byte, error in the high byte
  always @(posedge clk_in) begin
    rx_ev <= rx_ev + {7'h00, rx_err, 7'h00, rx_done};
  end

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic tmo(input logic hit);
    if (hit) begin
      mismatches++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in    <= a;
    wr_data_in <= d;
    wr_in      <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rchk(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    chk(what, {8'h00, rd_data_out}, {8'h00, exp});
  endtask

  // Three clocks let the enable synchroniser settle
  task automatic set(input logic [7:0] m);
    wr(`ASPC_ADDR_MODE, m);
    repeat (3) @(posedge clk_in);
  endtask

  task automatic t_regs();
    rchk(`ASPC_ADDR_MODE, 8'h01, "mode reset");
    rchk(`ASPC_ADDR_DATA, 8'hff, "holding reset");
    rchk(`ASPC_ADDR_STATUS, 8'h00, "status reset");
    wr(`ASPC_ADDR_DATA, 8'h00);
    rchk(`ASPC_ADDR_DATA, 8'hff, "holding not writable");
    rchk(16'hff7f, 8'h00, "unmapped read");
    wr(`ASPC_ADDR_MODE, 8'h9d);
    rchk(`ASPC_ADDR_MODE, 8'h9d, "mode write");
    wr(`ASPC_ADDR_BAUD, 8'(BAUD_K));
    $display("test regs done");
  endtask

  task automatic t_abort();
    int bad;
    bad = 0;
    set(8'h85);
    set(8'hc5);
    wr(`ASPC_ADDR_DATA, 8'h55);
    repeat (22) @(posedge clk_in);
    set(8'h85);
    wr(`ASPC_ADDR_DATA, 8'h00);
    for (int i = 0; i < 300; i++) begin
      @(negedge clk_in);
      bad += int'(tx_line !== 1'b1 || tx_done !== 1'b0);
    end
    chk("idle after tx disable", 16'(bad), 16'h0000);
    $display("test abort done");
  endtask

  task automatic t_tx();
    logic [3:0]  cfg [5];
    logic [11:0] got;
    logic [11:0] exp;
    logic [7:0]  d;
    logic        ok;
    int          len;
    int          nb;
    // {parity, eight bits, two stops}
    cfg = '{4'h2, 4'h6, 4'hb, 4'hc, 4'hf};
    for (int i = 0; i < 5; i++) begin
      set({3'h4, cfg[i], 1'b1});
      set({3'h6, cfg[i], 1'b1});
      d = 8'ha5 ^ 8'(i);
      exp = remote.frame(d, cfg[i][1] ? 8 : 7, cfg[i][3:2]);
      len = 0;
      wr(`ASPC_ADDR_DATA, d);
      fork
        remote.capture(got, ok);
        while (tx_done !== 1'b1 && len < 600) begin
          @(negedge clk_in);
          len++;
        end
      join
      tmo(!ok || len >= 600);
      chk("tx frame", {4'h0, got}, {4'h0, exp});
      nb = (cfg[i][1] ? 10 : 9) + int'(cfg[i][3:2] != 2'h0) + int'(cfg[i][0]);
      // Done shows on the first falling edge after the last stop bit time
      chk("tx length", 16'(len - nb * 2 * BAUD_K), 16'h0001);
      set({3'h4, cfg[i], 1'b1});
    end
    $display("test tx done");
  endtask

  task automatic rxone(input logic [7:0] d, input logic [3:0] cfg, input logic [11:0] flip,
                       input logic two, input logic [7:0] es, input string what);
    logic [15:0] ev;
    ev = rx_ev;
    set({3'h4, cfg, 1'b1});
    set({3'h5, cfg, 1'b1});
    remote.send(remote.frame(d, cfg[1] ? 8 : 7, cfg[3:2]) ^ flip);
    if (two) remote.send(remote.frame(~d, 8, cfg[3:2]));
    rchk(`ASPC_ADDR_DATA, cfg[1] ? d : {1'b0, d[6:0]}, what);
    rchk(`ASPC_ADDR_STATUS, es, what);
    chk(what, rx_ev - ev, {7'h00, es != 8'h00, 8'h01});
    set({3'h4, cfg, 1'b1});
  endtask

  task automatic t_rx();
    rxone(8'h3c, 4'he, 12'h000, 1'b0, 8'h00, "rx even");
    rxone(8'hff, 4'h8, 12'h000, 1'b0, 8'h00, "rx seven bit");
    rxone(8'h5a, 4'ha, 12'h200, 1'b0, 8'h04, "rx parity error");
    rxone(8'h5a, 4'h6, 12'h200, 1'b0, 8'h00, "rx zero parity");
    rxone(8'h3c, 4'h2, 12'h200, 1'b0, 8'h02, "rx frame error");
    rxone(8'h11, 4'h3, 12'h000, 1'b1, 8'h01, "rx overrun");
    $display("test rx done");
  endtask

  task automatic t_off();
    set(8'h87);
    set(8'h01);
    remote.send(12'h800);
    rchk(`ASPC_ADDR_DATA, 8'hff, "holding unpowered");
    rchk(`ASPC_ADDR_STATUS, 8'h00, "status unpowered");
    $display("test power off done");
  endtask

  initial begin
    rst_b_in   = 1'b0;
    addr_in    = 16'h0000;
    wr_data_in = 8'h00;
    wr_in      = 1'b0;
    rd_in      = 1'b0;
    mismatches = 0;
    tests_run  = 0;
    repeat (10) @(posedge clk_in);
    rst_b_in <= 1'b1;
    t_regs();
    t_abort();
    t_tx();
    t_rx();
    t_off();
    end_of_test();
  end
endmodule // aspc_core_test
`default_nettype wire

// File: testbench/aspc_remote.sv
/* Remote serial device: drives the core's receive line, samples its
   transmit line. Assumes a bit time of 2*K base clocks. */
`timescale 1ns/10ps
`default_nettype none
module aspc_remote #(
  parameter int K = 8
) (
  // Clock
  input  wire logic clk_in,
  // Serial lines
  input  wire logic tx_line_in,
  output var  logic rx_line_out
);
  initial rx_line_out = 1'b1;

  // Start low, data LSB first, parity, high stop and idle
  function automatic logic [11:0] frame(input logic [7:0] d, input int nd, input logic [1:0] par);
    logic [11:0] f;
    logic        p;
    f = 12'hffe;
    for (int i = 0; i < nd; i++) f[1 + i] = d[i];
    p = (^d[6:0]) ^ (nd == 8 && d[7]);
    if (par != 2'h0) f[1 + nd] = (par == 2'h1) ? 1'b0 : p ^ (par == 2'h2);
    return f;
  endfunction

  task automatic send(input logic [11:0] f);
    for (int i = 0; i < 12; i++) begin
      rx_line_out <= f[i];
      repeat (2 * K) @(posedge clk_in);
    end
  endtask

  // Samples on the falling edge, clear of the core's own updates
  task automatic capture(output logic [11:0] f, output logic ok);
    ok = 1'b0;
    for (int t = 0; t < 100 && !ok; t++) begin
      @(negedge clk_in);
      ok = (tx_line_in === 1'b0);
    end
    for (int i = 0; i < 12; i++) begin
      repeat (i == 0 ? K : 2 * K) @(negedge clk_in);
      f[i] = tx_line_in;
    end
  endtask
endmodule // aspc_remote
`default_nettype wire
